// ---- verilog/ddt_pkg.sv ----
// ddt_pkg: constants and carrier types for the dual down timer block
// Operation
// - timer A: 8-bit down counter, prescaled tick
// - write loads reload and count; read live
// - timer A counts only while enabled
// - clock select: external A or instruction clock
// - edge select: falling when 1, rising when 0
// - prescaler enable low, ratio 2..256, readable
// - single shot: count to zero, then stop
// - continuous: restart from reload or 0xFF
// - timer A underflow flag, irq, write-zero clear
// - timer A underflow routed to timer B
// - pwm A enable drives pin as output
// - pwm A polarity: active low when set
// - duty zero never active; 0xFF 255 clocks
// - tone A enable drives pin as output
// - tone source prescaler or underflow, divided
// - timer B mirrors timer A counter behaviour
// - chained mode: timer B clocked by A underflow
// - timer B prescaler, single shot, reload alike
// - timer B underflow flag bit 5, irq
// - pwm B mirrors pwm A
// - tone B mirrors tone A
// - chained mode keeps other functions separate
package ddt_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_A_ONE   = 8'h00;
    localparam logic [7:0] ADDR_A_TWO   = 8'h04;
    localparam logic [7:0] ADDR_A_COUNT = 8'h08;
    localparam logic [7:0] ADDR_A_DUTY  = 8'h0C;
    localparam logic [7:0] ADDR_A_TONE  = 8'h10;
    localparam logic [7:0] ADDR_A_PSV   = 8'h14;
    localparam logic [7:0] ADDR_B_ONE   = 8'h20;
    localparam logic [7:0] ADDR_B_TWO   = 8'h24;
    localparam logic [7:0] ADDR_B_COUNT = 8'h28;
    localparam logic [7:0] ADDR_B_DUTY  = 8'h2C;
    localparam logic [7:0] ADDR_B_TONE  = 8'h30;
    localparam logic [7:0] ADDR_B_PSV   = 8'h34;
    localparam logic [7:0] ADDR_FLAG    = 8'h40;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h44;
    localparam logic [7:0] ADDR_MODE    = 8'h48;
    // control one fields
    localparam int BIT_ENABLE  = 0;
    localparam int BIT_RELOAD  = 1;
    localparam int BIT_SHOT    = 2;
    localparam int BIT_PWM_POL = 6;
    localparam int BIT_PWM_OE  = 7;
    // control two fields
    localparam int RATIO_MSB   = 2;
    localparam int BIT_PS_EN_N = 3;
    localparam int BIT_EDGE    = 4;
    localparam int BIT_CLK_SEL = 5;
    // tone control fields
    localparam int BIT_TONE_SRC = 3;
    localparam int BIT_TONE_EN  = 7;
    // flag, irq enable and mode fields
    localparam int BIT_FLAG_A  = 3;
    localparam int BIT_FLAG_B  = 5;
    localparam int BIT_GIE     = 7;
    localparam int BIT_CHAIN   = 0;
    // reset and special values
    localparam logic [7:0] ONE_RST    = 8'h00;
    localparam logic [7:0] TWO_RST    = 8'h08;
    localparam logic [7:0] TONE_RST   = 8'h00;
    localparam logic [7:0] DUTY_RST   = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hFF;
    // per-timer configuration carried into the channel
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
        logic [7:0] tone;
        logic [7:0] duty;
    } ddt_cfg_type;
endpackage

// ---- verilog/ddt_channel.sv ----
// ddt_channel: one prescaler, down counter, pwm and tone generator
`timescale 1ns/1ps
`default_nettype none
module ddt_channel
    import ddt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire ddt_cfg_type cfg,
    input  wire logic        src_tick,
    input  wire logic        load,
    input  wire logic [7:0]  load_value,
    output logic      [7:0]  count,
    output logic      [7:0]  prescale_value,
    output logic             underflow,
    output logic             pwm_level,
    output logic             tone_level
);
    logic [7:0] reload;
    logic [7:0] next_reload;
    logic [7:0] next_count;
    logic [7:0] ps_cnt;
    logic [7:0] next_ps_cnt;
    logic [7:0] ps_mask;
    logic [6:0] tone_cnt;
    logic [6:0] next_tone_cnt;
    logic [6:0] tone_mask;
    logic       next_pwm;
    logic       next_tone;
    logic       ps_tick;
    logic       timer_tick;
    logic       tone_tick;

    // prescaler wraps every 2^(ratio+1) source ticks
    assign ps_mask = 8'((9'h002 << cfg.two[RATIO_MSB:0]) - 9'h001);
    assign ps_tick = src_tick && ((ps_cnt & ps_mask) == ps_mask);
    assign timer_tick = cfg.two[BIT_PS_EN_N] ? src_tick : ps_tick;
    // a load in the same cycle beats the underflow
    assign underflow = cfg.one[BIT_ENABLE] && timer_tick && !load
                       && (count == COUNT_ZERO);
    // tone toggles every 2^ratio ticks, so a full period is 2^(ratio+1)
    assign tone_mask = 7'((8'h01 << cfg.tone[RATIO_MSB:0]) - 8'h01);
    assign tone_tick = cfg.tone[BIT_TONE_SRC] ? underflow : timer_tick;
    assign prescale_value = ps_cnt;

    // next state of prescaler, counter, pwm and tone
    always_comb begin
        next_ps_cnt   = ps_cnt;
        next_reload   = reload;
        next_count    = count;
        next_tone_cnt = tone_cnt;
        next_tone     = tone_level;
        if (src_tick && !cfg.two[BIT_PS_EN_N]) begin
            next_ps_cnt = ps_cnt + 8'h01;
        end
        if (load) begin
            next_reload = load_value;
            next_count  = load_value;
        end else if (cfg.one[BIT_ENABLE] && timer_tick) begin
            if (count != COUNT_ZERO) begin
                next_count = count - 8'h01;
            end else if (cfg.one[BIT_SHOT]) begin
                next_count = COUNT_ZERO;
            end else if (cfg.one[BIT_RELOAD]) begin
                next_count = reload;
            end else begin
                next_count = COUNT_FULL;
            end
        end
        // zero in the count means frame end, never active
        next_pwm = ((count != COUNT_ZERO) && (count <= cfg.duty))
                   ^ cfg.one[BIT_PWM_POL];
        if (!cfg.tone[BIT_TONE_EN]) begin
            next_tone_cnt = 7'h00;
            next_tone     = 1'b0;
        end else if (tone_tick) begin
            next_tone_cnt = tone_cnt + 7'h01;
            if ((tone_cnt & tone_mask) == tone_mask) begin
                next_tone = !tone_level;
            end
        end
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_cnt     <= COUNT_ZERO;
            reload     <= COUNT_ZERO;
            count      <= COUNT_ZERO;
            tone_cnt   <= 7'h00;
            tone_level <= 1'b0;
            pwm_level  <= 1'b0;
        end else begin
            ps_cnt     <= next_ps_cnt;
            reload     <= next_reload;
            count      <= next_count;
            tone_cnt   <= next_tone_cnt;
            tone_level <= next_tone;
            pwm_level  <= next_pwm;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/ddt_top.sv ----
// ddt_top: apb registers, clock selection and pins of the two timers
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ddt_top
    import ddt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_clock_in_a,
    input  wire logic        ext_clock_in_b,
    output logic             pin_pwm_a_out,
    output logic             pin_pwm_a_oe,
    output logic             pin_tone_a_out,
    output logic             pin_tone_a_oe,
    output logic             pin_pwm_b_out,
    output logic             pin_pwm_b_oe,
    output logic             pin_tone_b_out,
    output logic             pin_tone_b_oe,
    output logic             irq_request
);
    ddt_cfg_type cfg_a;
    ddt_cfg_type cfg_b;
    ddt_cfg_type next_cfg_a;
    ddt_cfg_type next_cfg_b;
    logic [7:0]  irq_en;
    logic [7:0]  next_irq_en;
    logic        flag_a;
    logic        flag_b;
    logic        next_flag_a;
    logic        next_flag_b;
    logic        chain;
    logic        next_chain;
    logic        next_irq;
    logic [31:0] next_prdata;
    logic        mapped;
    logic        wr;
    logic        setup;
    logic        load_a;
    logic        load_b;
    logic [7:0]  count_a;
    logic [7:0]  count_b;
    logic [7:0]  psv_a;
    logic [7:0]  psv_b;
    logic        under_a;
    logic        under_b;
    logic        pwm_level_a;
    logic        pwm_level_b;
    logic        tone_level_a;
    logic        tone_level_b;
    logic        src_a;
    logic        src_b;
    logic        sel_b;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic        rise_a;
    logic        fall_a;
    logic        rise_b;
    logic        fall_b;
    logic        next_pwm_a_out;
    logic        next_tone_a_out;
    logic        next_pwm_b_out;
    logic        next_tone_b_out;

    // zero wait state slave: every access ends in its first access cycle
    assign pready = 1'b1;
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite;
    assign load_a = wr && (paddr == ADDR_A_COUNT);
    assign load_b = wr && (paddr == ADDR_B_COUNT);

    // external clocks: two stages, then a third only for edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {sync_a[1:0], ext_clock_in_a};
            sync_b <= {sync_b[1:0], ext_clock_in_b};
        end
    end

    // edges seen only from the second stage onwards
    assign rise_a = sync_a[1] && !sync_a[2];
    assign fall_a = !sync_a[1] && sync_a[2];
    assign rise_b = sync_b[1] && !sync_b[2];
    assign fall_b = !sync_b[1] && sync_b[2];

    // source tick: instruction clock is every pclk, else the chosen edge
    always_comb begin
        if (cfg_a.two[BIT_CLK_SEL]) begin
            src_a = cfg_a.two[BIT_EDGE] ? fall_a : rise_a;
        end else begin
            src_a = 1'b1;
        end
        if (cfg_b.two[BIT_CLK_SEL]) begin
            sel_b = cfg_b.two[BIT_EDGE] ? fall_b : rise_b;
        end else begin
            sel_b = 1'b1;
        end
        // chaining swaps only the source; prescaler still applies
        src_b = chain ? under_a : sel_b;
    end

    // timer A channel
    ddt_channel u_chan_a (
        .pclk           (pclk),
        .presetn        (presetn),
        .cfg            (cfg_a),
        .src_tick       (src_a),
        .load           (load_a),
        .load_value     (pwdata[7:0]),
        .count          (count_a),
        .prescale_value (psv_a),
        .underflow      (under_a),
        .pwm_level      (pwm_level_a),
        .tone_level     (tone_level_a)
    );

    // timer B channel, same logic as A
    ddt_channel u_chan_b (
        .pclk           (pclk),
        .presetn        (presetn),
        .cfg            (cfg_b),
        .src_tick       (src_b),
        .load           (load_b),
        .load_value     (pwdata[7:0]),
        .count          (count_b),
        .prescale_value (psv_b),
        .underflow      (under_b),
        .pwm_level      (pwm_level_b),
        .tone_level     (tone_level_b)
    );

    // read mux, sampled in the setup cycle so prdata is a flop
    always_comb begin
        next_prdata = prdata;
        mapped      = 1'b1;
        case (paddr)
            ADDR_A_ONE:   next_prdata = {24'h00_0000, cfg_a.one};
            ADDR_A_TWO:   next_prdata = {24'h00_0000, cfg_a.two};
            ADDR_A_COUNT: next_prdata = {24'h00_0000, count_a};
            ADDR_A_DUTY:  next_prdata = {24'h00_0000, cfg_a.duty};
            ADDR_A_TONE:  next_prdata = {24'h00_0000, cfg_a.tone};
            ADDR_A_PSV:   next_prdata = {24'h00_0000, psv_a};
            ADDR_B_ONE:   next_prdata = {24'h00_0000, cfg_b.one};
            ADDR_B_TWO:   next_prdata = {24'h00_0000, cfg_b.two};
            ADDR_B_COUNT: next_prdata = {24'h00_0000, count_b};
            ADDR_B_DUTY:  next_prdata = {24'h00_0000, cfg_b.duty};
            ADDR_B_TONE:  next_prdata = {24'h00_0000, cfg_b.tone};
            ADDR_B_PSV:   next_prdata = {24'h00_0000, psv_b};
            ADDR_FLAG: begin
                next_prdata             = 32'h0000_0000;
                next_prdata[BIT_FLAG_A] = flag_a;
                next_prdata[BIT_FLAG_B] = flag_b;
            end
            ADDR_IRQ_EN:  next_prdata = {24'h00_0000, irq_en};
            ADDR_MODE:    next_prdata = {31'h0000_0000, chain};
            default: begin
                next_prdata = 32'h0000_0000;
                mapped      = 1'b0;
            end
        endcase
        if (!setup || pwrite) begin
            next_prdata = prdata;
        end
    end

    // unmapped addresses answer with an error, writes there are dropped
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // register writes plus hardware updates of enables and flags
    always_comb begin
        next_cfg_a  = cfg_a;
        next_cfg_b  = cfg_b;
        next_irq_en = irq_en;
        next_chain  = chain;
        next_flag_a = flag_a;
        next_flag_b = flag_b;
        // single shot drops its own enable after the underflow
        if (under_a && cfg_a.one[BIT_SHOT]) begin
            next_cfg_a.one[BIT_ENABLE] = 1'b0;
        end
        if (under_b && cfg_b.one[BIT_SHOT]) begin
            next_cfg_b.one[BIT_ENABLE] = 1'b0;
        end
        if (wr) begin
            case (paddr)
                ADDR_A_ONE:  next_cfg_a.one  = pwdata[7:0];
                ADDR_A_TWO:  next_cfg_a.two  = pwdata[7:0];
                ADDR_A_DUTY: next_cfg_a.duty = pwdata[7:0];
                ADDR_A_TONE: next_cfg_a.tone = pwdata[7:0];
                ADDR_B_ONE:  next_cfg_b.one  = pwdata[7:0];
                ADDR_B_TWO:  next_cfg_b.two  = pwdata[7:0];
                ADDR_B_DUTY: next_cfg_b.duty = pwdata[7:0];
                ADDR_B_TONE: next_cfg_b.tone = pwdata[7:0];
                ADDR_IRQ_EN: next_irq_en     = pwdata[7:0];
                ADDR_MODE:   next_chain      = pwdata[BIT_CHAIN];
                ADDR_FLAG: begin
                    // writing zero clears, writing one keeps
                    if (!pwdata[BIT_FLAG_A]) begin
                        next_flag_a = 1'b0;
                    end
                    if (!pwdata[BIT_FLAG_B]) begin
                        next_flag_b = 1'b0;
                    end
                end
                default: begin
                    next_chain = chain;
                end
            endcase
        end
        // a new underflow wins over a clear in the same cycle
        if (under_a) begin
            next_flag_a = 1'b1;
        end
        if (under_b) begin
            next_flag_b = 1'b1;
        end
        next_irq = irq_en[BIT_GIE]
                   && ((flag_a && irq_en[BIT_FLAG_A])
                   || (flag_b && irq_en[BIT_FLAG_B]));
    end

    // pin drive: enable forces output, disabled pin goes back to gpio
    always_comb begin
        next_pwm_a_out  = cfg_a.one[BIT_PWM_OE] && pwm_level_a;
        next_pwm_b_out  = cfg_b.one[BIT_PWM_OE] && pwm_level_b;
        next_tone_a_out = cfg_a.tone[BIT_TONE_EN] && tone_level_a;
        next_tone_b_out = cfg_b.tone[BIT_TONE_EN] && tone_level_b;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_a          <= '{ONE_RST, TWO_RST, TONE_RST, DUTY_RST};
            cfg_b          <= '{ONE_RST, TWO_RST, TONE_RST, DUTY_RST};
            irq_en         <= IRQ_EN_RST;
            chain          <= 1'b0;
            flag_a         <= 1'b0;
            flag_b         <= 1'b0;
            irq_request    <= 1'b0;
            pin_pwm_a_out  <= 1'b0;
            pin_pwm_b_out  <= 1'b0;
            pin_tone_a_out <= 1'b0;
            pin_tone_b_out <= 1'b0;
            pin_pwm_a_oe   <= 1'b0;
            pin_pwm_b_oe   <= 1'b0;
            pin_tone_a_oe  <= 1'b0;
            pin_tone_b_oe  <= 1'b0;
        end else begin
            cfg_a          <= next_cfg_a;
            cfg_b          <= next_cfg_b;
            irq_en         <= next_irq_en;
            chain          <= next_chain;
            flag_a         <= next_flag_a;
            flag_b         <= next_flag_b;
            irq_request    <= next_irq;
            pin_pwm_a_out  <= next_pwm_a_out;
            pin_pwm_b_out  <= next_pwm_b_out;
            pin_tone_a_out <= next_tone_a_out;
            pin_tone_b_out <= next_tone_b_out;
            pin_pwm_a_oe   <= cfg_a.one[BIT_PWM_OE];
            pin_pwm_b_oe   <= cfg_b.one[BIT_PWM_OE];
            pin_tone_a_oe  <= cfg_a.tone[BIT_TONE_EN];
            pin_tone_b_oe  <= cfg_b.tone[BIT_TONE_EN];
        end
    end

    // underflow always leaves the flag set one cycle later
    property p_flag_a_set;
        @(posedge pclk) disable iff (!presetn)
        under_a |=> flag_a;
    endproperty
    a_flag_a_set: assert property (p_flag_a_set)
        else $error("timer A underflow did not set its flag");

    // a pending enabled flag raises the request next cycle
    property p_irq_b;
        @(posedge pclk) disable iff (!presetn)
        (flag_b && irq_en[BIT_FLAG_B] && irq_en[BIT_GIE]) |=> irq_request;
    endproperty
    a_irq_b: assert property (p_irq_b)
        else $error("timer B flag with enables gave no request");

    // a count write shows up as the live count
    property p_load_a;
        @(posedge pclk) disable iff (!presetn)
        load_a |=> (count_a == $past(pwdata[7:0]));
    endproperty
    a_load_a: assert property (p_load_a)
        else $error("timer A count write not loaded");

    // a disabled timer holds its count for two cycles
    property p_hold_a;
        @(posedge pclk) disable iff (!presetn)
        (!cfg_a.one[BIT_ENABLE] && !load_a)[*2] |=> $stable(count_a);
    endproperty
    a_hold_a: assert property (p_hold_a)
        else $error("disabled timer A changed count");

    // single shot stops the timer after its underflow
    property p_shot_a;
        @(posedge pclk) disable iff (!presetn)
        (under_a && cfg_a.one[BIT_SHOT] && !wr)
        |=> !cfg_a.one[BIT_ENABLE] ##1 (count_a == COUNT_ZERO);
    endproperty
    a_shot_a: assert property (p_shot_a)
        else $error("single shot timer A kept running");

    // free running without reload restarts at all ones
    property p_full_b;
        @(posedge pclk) disable iff (!presetn)
        (under_b && !cfg_b.one[BIT_SHOT] && !cfg_b.one[BIT_RELOAD])
        |=> (count_b == COUNT_FULL);
    endproperty
    a_full_b: assert property (p_full_b)
        else $error("timer B did not restart from all ones");

    // duty zero keeps the pwm level at its inactive polarity
    property p_pwm_zero_a;
        @(posedge pclk) disable iff (!presetn)
        (cfg_a.duty == DUTY_RST)
        |=> (pwm_level_a == $past(cfg_a.one[BIT_PWM_POL]));
    endproperty
    a_pwm_zero_a: assert property (p_pwm_zero_a)
        else $error("pwm A active with zero duty");

    // chained timer B with its prescaler off steps once per timer A underflow
    property p_chain;
        @(posedge pclk) disable iff (!presetn)
        (chain && under_a && cfg_b.one[BIT_ENABLE]
         && cfg_b.two[BIT_PS_EN_N] && !load_b && (count_b != COUNT_ZERO))
        |=> (count_b == $past(count_b) - 8'h01);
    endproperty
    a_chain: assert property (p_chain)
        else $error("chained timer B missed the underflow of A");

    // disabled tone releases its pin within two cycles
    property p_tone_off_b;
        @(posedge pclk) disable iff (!presetn)
        !cfg_b.tone[BIT_TONE_EN] |-> ##[1:2] (!pin_tone_b_oe && !pin_tone_b_out);
    endproperty
    a_tone_off_b: assert property (p_tone_off_b)
        else $error("tone B pin still driven while disabled");
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// tb: self-checking apb bench for the dual down timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ddt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, ext_a, ext_b;
    logic [7:0]  paddr, o, m, v;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq;
    wire  [7:0]  pins;
    logic [32:0] notes[$];
    int          err_count, samples_checked, cycles, t, i;
    // ext clock cases: ctrl two, ctrl one, load, pulses, count, flag
    logic [7:0]  c_two[3] = '{8'h28, 8'h38, 8'h20};
    logic [7:0]  c_one[3] = '{8'h01, 8'h03, 8'h01};
    logic [7:0]  c_ld[3]  = '{8'h02, 8'h02, 8'h09};
    logic [7:0]  c_cnt[3] = '{8'hFE, 8'h01, 8'h06};
    logic [7:0]  c_fl[3]  = '{8'h01, 8'h01, 8'h00};
    int          c_k[3]   = '{3, 4, 5};

    ddt_top i_ddt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clock_in_a(ext_a), .ext_clock_in_b(ext_b),
        .pin_pwm_a_out(pins[7]), .pin_pwm_a_oe(pins[6]),
        .pin_tone_a_out(pins[5]), .pin_tone_a_oe(pins[4]),
        .pin_pwm_b_out(pins[3]), .pin_pwm_b_oe(pins[2]),
        .pin_tone_b_out(pins[1]), .pin_tone_b_oe(pins[0]),
        .irq_request(irq));

    task automatic check(input string what, input logic [32:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        apb(1'b1, a, d);
    endtask

    // a read leaves its expectation for the monitor below
    task automatic rd(input logic [7:0] a, d, input logic e);
        notes.push_back({e, 24'h00_0000, d});
        apb(1'b0, a, 8'h00);
    endtask

    // level change on an ext clock, held long enough for the synchroniser
    task automatic edge_to(input int s, input logic lv);
        @(posedge pclk);
        if (s != 0) ext_b <= lv;
        else ext_a <= lv;
        repeat (4) @(posedge pclk);
    endtask

    // read data and error are judged at the access edge, oldest note first
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check("read", {pslverr, prdata}, notes.pop_front());
        end
    end

    // hang guard: the whole run needs under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, ext_a, ext_b} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        void'($urandom(32'h0000_7e5f));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_A_TWO, TWO_RST, 1'b0);
        rd(ADDR_B_ONE, ONE_RST, 1'b0);
        rd(8'h3C, 8'h00, 1'b1);
        // random load while disabled must be seen and held
        v = 8'($urandom);
        wr(ADDR_A_COUNT, v);
        rd(ADDR_A_COUNT, v, 1'b0);
        repeat (10) @(posedge pclk);
        rd(ADDR_A_COUNT, v, 1'b0);
        // single shot on the instruction clock stops at zero
        wr(ADDR_A_COUNT, 8'h05);
        wr(ADDR_A_ONE, 8'h05);
        repeat (20) @(posedge pclk);
        rd(ADDR_A_COUNT, COUNT_ZERO, 1'b0);
        rd(ADDR_A_ONE, 8'h04, 1'b0);
        rd(ADDR_FLAG, 8'h08, 1'b0);
        wr(ADDR_FLAG, 8'h00);
        rd(ADDR_FLAG, 8'h00, 1'b0);
        // both timer requests enabled so each burst also judges the irq
        wr(ADDR_IRQ_EN, 8'hA8);
        // counted ext edges: one rise more than falls ends each burst
        for (int n = 0; n < 6; n++) begin
            t = n / 3;
            i = n % 3;
            o = (t != 0) ? 8'h20 : 8'h00;
            wr(ADDR_A_ONE + o, 8'h00);
            edge_to(t, 1'b0);
            wr(ADDR_FLAG, 8'h00);
            wr(ADDR_A_TWO + o, c_two[i]);
            wr(ADDR_A_COUNT + o, c_ld[i]);
            wr(ADDR_A_ONE + o, c_one[i]);
            repeat (c_k[i]) begin
                edge_to(t, 1'b1);
                edge_to(t, 1'b0);
            end
            edge_to(t, 1'b1);
            rd(ADDR_A_COUNT + o, c_cnt[i], 1'b0);
            rd(ADDR_FLAG, c_fl[i] << ((t != 0) ? 5 : 3), 1'b0);
            check("irq", {32'h0000_0000, irq}, {32'h0000_0000, c_fl[i][0]});
        end
        // chained: every timer A underflow ticks timer B once
        wr(ADDR_B_ONE, 8'h00);
        wr(ADDR_B_TWO, TWO_RST);
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_B_COUNT, 8'h05);
        wr(ADDR_B_ONE, 8'h01);
        wr(ADDR_A_ONE, 8'h00);
        edge_to(0, 1'b0);
        wr(ADDR_FLAG, 8'h00);
        wr(ADDR_A_TWO, 8'h28);
        wr(ADDR_A_COUNT, 8'h00);
        wr(ADDR_A_ONE, 8'h03);
        repeat (2) begin
            edge_to(0, 1'b1);
            edge_to(0, 1'b0);
        end
        edge_to(0, 1'b1);
        rd(ADDR_B_COUNT, 8'h02, 1'b0);
        rd(ADDR_FLAG, 8'h08, 1'b0);
        // request needs the global enable as well as the timer enable
        wr(ADDR_IRQ_EN, 8'h88);
        repeat (4) @(posedge pclk);
        check("irq", {32'h0000_0000, irq}, 33'h0_0000_0001);
        wr(ADDR_IRQ_EN, 8'h08);
        repeat (4) @(posedge pclk);
        check("irq", {32'h0000_0000, irq}, 33'h0_0000_0000);
        // leave chained mode so timer B runs on the instruction clock
        wr(ADDR_MODE, 8'h00);
        // pins: duty zero active low idles high; tone half period 2 ticks
        for (int n = 0; n < 2; n++) begin
            o = (n != 0) ? 8'h20 : 8'h00;
            m = (n != 0) ? 8'h0D : 8'hD0;
            i = (n != 0) ? 1 : 5;
            wr(ADDR_A_DUTY + o, 8'h00);
            wr(ADDR_A_ONE + o, 8'hC0);
            wr(ADDR_A_TWO + o, TWO_RST);
            wr(ADDR_A_TONE + o, 8'h81);
            repeat (4) @(posedge pclk);
            check("pins", {25'h0, pins & m}, {25'h0, m});
            v = pins;
            repeat (2) @(posedge pclk);
            check("tone", {32'h0000_0000, v[i] ^ pins[i]}, 33'h0_0000_0001);
            repeat (2) @(posedge pclk);
            check("tone", {32'h0000_0000, v[i] ^ pins[i]}, 33'h0_0000_0000);
            wr(ADDR_A_ONE + o, 8'h00);
            wr(ADDR_A_TONE + o, 8'h00);
            repeat (4) @(posedge pclk);
            check("pins", {25'h0, pins & m}, 33'h0);
        end
        final_report();
    end
endmodule
`default_nettype wire
